// file: core/atrf_defs.svh
// offsets, field positions, reset values and timing counts of the trigger and result block
`ifndef ATRF_DEFS_SVH
`define ATRF_DEFS_SVH

`define ATRF_ADDR_CONV_CONTROL_0  3'h0
`define ATRF_ADDR_CONV_CONTROL_1  3'h1
`define ATRF_ADDR_TRIGGER_SELECT  3'h2
`define ATRF_ADDR_RESULT_HIGH     3'h3
`define ATRF_ADDR_RESULT_LOW      3'h4

`define ATRF_CTL0_ENABLE_BIT      0
`define ATRF_CTL0_START_BIT       1
`define ATRF_CTL1_JUSTIFY_BIT     7
`define ATRF_CTL1_UNUSED_BIT      3

`define ATRF_CTL0_RESET           8'h00
`define ATRF_CTL1_RESET           8'h00
`define ATRF_TRIGGER_RESET        4'h0

`define ATRF_CONV_TIME_NS         11000
`define ATRF_CLK_PERIOD_NS        8
`define ATRF_CONV_CYCLES          ((`ATRF_CONV_TIME_NS + `ATRF_CLK_PERIOD_NS - 1) / `ATRF_CLK_PERIOD_NS)

`endif

// file: core/atrf_edge_detect.sv
// two-stage synchroniser followed by a rising-edge detector
module atrf_edge_detect (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      rise
);
  logic meta;
  logic sync;
  logic last;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise = sync & ~last;
endmodule

// file: core/atrf_pkg.sv
// types of the trigger and result block
package atrf_pkg;
  typedef enum logic [3:0] {
    ATRF_TRIG_NONE     = 4'h0,
    ATRF_TRIG_TIMER0   = 4'h3,
    ATRF_TRIG_TIMER1   = 4'h4,
    ATRF_TRIG_TIMER2   = 4'h5,
    ATRF_TRIG_COMP1    = 4'h6,
    ATRF_TRIG_COMP2    = 4'h7,
    ATRF_TRIG_CELL1    = 4'h8,
    ATRF_TRIG_CELL2    = 4'h9,
    ATRF_TRIG_CAPTURE1 = 4'hc,
    ATRF_TRIG_CAPTURE2 = 4'hd
  } atrf_trigger_t;

  typedef enum {
    ATRF_IDLE,
    ATRF_CONVERT
  } atrf_state_t;
endpackage

// file: core/atrf_result_format.sv
// places the 10-bit result into the high and low bytes by justification
module atrf_result_format (
  input  wire logic [9:0] conversion_result,
  input  wire logic       result_justify,
  output logic      [7:0] next_high,
  output logic      [7:0] next_low
);
  always_comb begin
    if (result_justify) begin
      next_high = {6'h00, conversion_result[9:8]}; // R10
      next_low  = conversion_result[7:0]; // R11
    end else begin
      next_high = conversion_result[9:2]; // R08
      next_low  = {conversion_result[1:0], 6'h00}; // R09
    end
  end
endmodule

// file: core/atrf_top.sv
// auto-conversion trigger selection and result byte registers
// What this block does
// R01: four-bit trigger field in low nibble; code zero disables hardware triggers.
// R02: codes 3 and 4 pick timer overflows; code 5 picks timer-two period match.
// R03: codes 6 and 7 pick comparators one and two; two only on large package.
// R04: codes 8,9 logic cells; 12,13 capture units; others reserved.
// R05: every source triggers only on its rising edge, never on level.
// R06: timer triggers coincide with the timer setting its interrupt flag.
// R07: upper nibble of trigger register has no storage and reads zero.
// R08: left justified, high byte holds result bits nine to two.
// R09: left justified, low byte bits seven and six hold result bits one, zero.
// R10: right justified, high byte bits one and zero hold result bits nine, eight.
// R11: right justified, low byte holds result bits seven to zero.
// R12: result bytes read/write, undefined at power-on, kept across other resets.
// R13: trigger field clears to zero on every reset source.
// R14: rising edge on selected source starts conversion like the start bit, if enabled.
`include "atrf_defs.svh"
module atrf_top (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer0_flag,
  input  wire logic       timer1_flag,
  input  wire logic       timer_two_period_match,
  input  wire logic       comparator_1,
  input  wire logic       comparator_2,
  input  wire logic       logic_cell_1,
  input  wire logic       logic_cell_2,
  input  wire logic       capture_unit_1,
  input  wire logic       capture_unit_2,
  output logic            conversion_start,
  input  wire logic       conversion_done,
  input  wire logic [9:0] conversion_result
);
  import atrf_pkg::*;

  localparam int NSRC = 9;

  logic [7:0]      conv_control_0;
  logic [7:0]      conv_control_1;
  logic [3:0]      auto_trigger_select;
  logic [7:0]      result_high_byte;
  logic [7:0]      result_low_byte;
  logic [NSRC-1:0] src_in;
  logic [NSRC-1:0] src_rise;
  logic            trig_rise;
  logic            start_pulse;
  logic            converter_enable;
  logic            next_enable;
  logic            result_justify;
  logic [7:0]      next_high;
  logic [7:0]      next_low;
  logic            done_seen;
  atrf_state_t     state;

  assign converter_enable = conv_control_0[`ATRF_CTL0_ENABLE_BIT];
  assign result_justify   = conv_control_1[`ATRF_CTL1_JUSTIFY_BIT];
  // a ctl0 write acts on the enable it writes, so a disabling write never fires a start
  assign next_enable = (reg_write && reg_addr == `ATRF_ADDR_CONV_CONTROL_0) ?
                       reg_wdata[`ATRF_CTL0_ENABLE_BIT] : converter_enable;

  assign src_in = {capture_unit_2, capture_unit_1, logic_cell_2, logic_cell_1,
                   comparator_2, comparator_1, timer_two_period_match,
                   timer1_flag, timer0_flag};

  // timer inputs are the timers' interrupt flags, so the edge is the flag setting
  // R06
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gen_src
      atrf_edge_detect u_edge (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (src_in[g]),
        .rise     (src_rise[g])
      ); // R05
    end
  endgenerate

  // reserved codes select nothing, so they behave like the disabled code
  always_comb begin
    case (atrf_trigger_t'(auto_trigger_select))
      ATRF_TRIG_NONE:     trig_rise = 1'b0; // R01
      ATRF_TRIG_TIMER0:   trig_rise = src_rise[0]; // R02
      ATRF_TRIG_TIMER1:   trig_rise = src_rise[1]; // R02
      ATRF_TRIG_TIMER2:   trig_rise = src_rise[2]; // R02
      ATRF_TRIG_COMP1:    trig_rise = src_rise[3]; // R03
      ATRF_TRIG_COMP2:    trig_rise = src_rise[4]; // R03
      ATRF_TRIG_CELL1:    trig_rise = src_rise[5]; // R04
      ATRF_TRIG_CELL2:    trig_rise = src_rise[6]; // R04
      ATRF_TRIG_CAPTURE1: trig_rise = src_rise[7]; // R04
      ATRF_TRIG_CAPTURE2: trig_rise = src_rise[8]; // R04
      default:            trig_rise = 1'b0; // R04
    endcase
  end

  // software write of the start bit or a selected edge, both gated by enable
  assign start_pulse = next_enable & (state == ATRF_IDLE) &
                       (trig_rise |
                        (reg_write & (reg_addr == `ATRF_ADDR_CONV_CONTROL_0) &
                         reg_wdata[`ATRF_CTL0_START_BIT])); // R14
  assign conversion_start = start_pulse;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ATRF_IDLE;
    end else begin
      case (state)
        ATRF_IDLE: begin
          if (start_pulse) begin
            state <= ATRF_CONVERT;
          end
        end
        ATRF_CONVERT: begin
          if (conversion_done || !next_enable) begin
            state <= ATRF_IDLE;
          end
        end
        default: state <= ATRF_IDLE;
      endcase
    end
  end

  assign done_seen = (state == ATRF_CONVERT) & conversion_done & converter_enable;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_control_0 <= `ATRF_CTL0_RESET;
    end else if (reg_write && reg_addr == `ATRF_ADDR_CONV_CONTROL_0) begin
      conv_control_0 <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_control_1 <= `ATRF_CTL1_RESET;
    end else if (reg_write && reg_addr == `ATRF_ADDR_CONV_CONTROL_1) begin
      conv_control_1 <= reg_wdata;
      conv_control_1[`ATRF_CTL1_UNUSED_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_trigger_select <= `ATRF_TRIGGER_RESET; // R13
    end else if (reg_write && reg_addr == `ATRF_ADDR_TRIGGER_SELECT) begin
      auto_trigger_select <= reg_wdata[3:0]; // R01
    end
  end

  atrf_result_format u_format (
    .conversion_result (conversion_result),
    .result_justify    (result_justify),
    .next_high         (next_high),
    .next_low          (next_low)
  );

  // no reset: contents survive resets; power-on value is whatever the flops wake with
  // a finishing conversion wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (done_seen) begin
      result_high_byte <= next_high; // R12
      result_low_byte  <= next_low;
    end else if (reg_write && reg_addr == `ATRF_ADDR_RESULT_HIGH) begin
      result_high_byte <= reg_wdata; // R12
    end else if (reg_write && reg_addr == `ATRF_ADDR_RESULT_LOW) begin
      result_low_byte <= reg_wdata; // R12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ATRF_ADDR_CONV_CONTROL_0: reg_rdata <= {conv_control_0[7:2], state == ATRF_CONVERT, conv_control_0[0]};
        `ATRF_ADDR_CONV_CONTROL_1: reg_rdata <= conv_control_1;
        `ATRF_ADDR_TRIGGER_SELECT: reg_rdata <= {4'h0, auto_trigger_select}; // R07
        `ATRF_ADDR_RESULT_HIGH:    reg_rdata <= result_high_byte;
        `ATRF_ADDR_RESULT_LOW:     reg_rdata <= result_low_byte;
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// file: tb/atrf_checker.sv
// port assertions of the trigger and result block
module atrf_checker (
  input logic       clk,
  input logic       resetn,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_write,
  input logic       reg_read,
  input logic [7:0] reg_rdata,
  input logic       conversion_start,
  input logic       conversion_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic busy;
  // a software clear of enable ends a conversion early
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busy <= 1'b0;
    else busy <= conversion_start || (busy && !conversion_done && !(reg_write && reg_addr == 3'h0 && !reg_wdata[0]));
  end
  property p_trig_rd; $past(reg_read) && $past(reg_addr) == 3'h2 |-> reg_rdata[7:4] == 4'h0; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trig nibble set");
  property p_trig_wr; reg_write && reg_addr == 3'h2 ##1 reg_read && reg_addr == 3'h2
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f); endproperty
  a_trig_wr: assert property (p_trig_wr) else $error("trig readback");
  property p_start_one; conversion_start |=> !conversion_start; endproperty
  a_start_one: assert property (p_start_one) else $error("start too long");
  property p_start_sw; reg_write && reg_addr == 3'h0 && reg_wdata[1:0] == 2'b11 && !busy |-> conversion_start;
  endproperty
  a_start_sw: assert property (p_start_sw) else $error("no sw start");
  property p_start_dis; reg_write && reg_addr == 3'h0 && !reg_wdata[0] |-> !conversion_start; endproperty
  a_start_dis: assert property (p_start_dis) else $error("start while off");
  property p_busy_rd; conversion_start ##1 reg_read && reg_addr == 3'h0 && !conversion_done |=> reg_rdata[1];
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy not shown");
  property p_res_lo; reg_write && reg_addr == 3'h4 && !conversion_done ##1 reg_read && reg_addr == 3'h4
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_res_lo: assert property (p_res_lo) else $error("low byte rw");
  property p_res_hi; reg_write && reg_addr == 3'h3 && !conversion_done ##1 reg_read && reg_addr == 3'h3
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_res_hi: assert property (p_res_hi) else $error("high byte rw");
endmodule

// file: tb/atrf_seq_model.sv
// sequencer stand-in: one done pulse lat cycles after each start
module atrf_seq_model (
  input  logic       clk,
  input  logic       resetn,
  input  logic       start,
  input  logic [9:0] value,
  input  int         lat,
  output logic       done,
  output logic [9:0] result
);
  int cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt <= 0;
    else if (start) cnt <= lat;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign done = cnt == 1;
  // inverse outside done so a mistimed sample cannot match
  assign result = done ? value : ~value;
endmodule

// file: tb/testbench.sv
// self-checking bench of the trigger and result block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, reg_write = 0, reg_read = 0, pend = 0, done, start, j;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, rexp, d;
  logic [8:0] src = 0;
  logic [9:0] val = 0, res;
  int lat = 4, fails = 0, tests_run = 0, nst = 0, cyc = 0, n0, ks = -1, hit = -1;
  always #4 clk = ~clk;
  atrf_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .timer0_flag(src[0]), .timer1_flag(src[1]),
    .timer_two_period_match(src[2]), .comparator_1(src[3]), .comparator_2(src[4]), .logic_cell_1(src[5]),
    .logic_cell_2(src[6]), .capture_unit_1(src[7]), .capture_unit_2(src[8]), .conversion_start(start),
    .conversion_done(done), .conversion_result(res));
  atrf_seq_model seq (.clk(clk), .resetn(resetn), .start(start), .value(val), .lat(lat), .done(done), .result(res));
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // during a read the data lines carry the expected value for the monitor
  task automatic bus(logic w, logic r, logic [2:0] a, logic [7:0] v);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
  endtask
  task automatic idle(int n);
    repeat (n) bus(0, 0, 3'h0, 8'h00);
  endtask
  function automatic int sel(int c);
    return (c >= 3 && c <= 9) ? c - 3 : (c == 12 || c == 13) ? c - 5 : -1;
  endfunction
  function automatic logic [7:0] fmt(logic [9:0] v, logic j, logic lo);
    return lo ? (j ? v[7:0] : {v[1:0], 6'h00}) : (j ? {6'h00, v[9:8]} : v[9:2]);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (start) begin
      nst++;
      hit = ks;
    end
    if (pend) chk("reg_rdata", rexp, reg_rdata);
    pend = reg_read;
    rexp = reg_wdata;
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'he2127f1b));
    repeat (8) @(posedge clk);
    resetn <= 1;
    bus(0, 1, 3'h2, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      bus(1, 0, 3'h2, d);
      bus(0, 1, 3'h2, {4'h0, d[3:0]});
      bus(1, 0, 3'h4, d);
      bus(0, 1, 3'h4, d);
      bus(1, 0, 3'h3, ~d);
      bus(0, 1, 3'h3, ~d);
    end
    for (int c = 0; c < 16; c++) begin
      j = 1'($urandom);
      val <= 10'($urandom);
      lat <= 2 + int'($urandom % 5);
      bus(1, 0, 3'h0, 8'h01);
      bus(1, 0, 3'h1, {j, 7'h00});
      bus(1, 0, 3'h2, 8'(c));
      idle(2);
      n0 = nst;
      hit = -1;
      // level held past the end of the conversion must not start another
      for (int k = 0; k < 9; k++) begin
        ks = k;
        src[k] <= 1;
        idle(12);
        src[k] <= 0;
        idle(6);
      end
      chk("starts", sel(c) >= 0, nst - n0);
      if (sel(c) >= 0) begin
        chk("source", sel(c), hit);
        bus(0, 1, 3'h3, fmt(val, j, 0));
        bus(0, 1, 3'h4, fmt(val, j, 1));
      end
    end
    n0 = nst;
    bus(1, 0, 3'h2, 8'h00);
    bus(1, 0, 3'h0, 8'h03);
    bus(0, 1, 3'h0, 8'h03);
    idle(8);
    bus(1, 0, 3'h0, 8'h00);
    bus(1, 0, 3'h2, 8'h03);
    src[0] <= 1;
    idle(8);
    src[0] <= 0;
    chk("starts", 1, nst - n0);
    bus(1, 0, 3'h3, 8'h5a);
    bus(1, 0, 3'h2, 8'h0d);
    idle(1);
    resetn <= 0;
    idle(2);
    resetn <= 1;
    bus(0, 1, 3'h2, 8'h00);
    bus(0, 1, 3'h3, 8'h5a);
    idle(2);
    report_and_stop;
  end
endmodule
bind atrf_top atrf_checker u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .conversion_start(conversion_start),
  .conversion_done(conversion_done));
